// file: mbs_pkg.sv
// constants and carrier types for the drive parameter slave command layer
// assumes framing, silence timing and crc are checked upstream
package mbs_pkg;
    localparam logic [7:0] FC_READ_COILS = 8'h01;
    localparam logic [7:0] FC_READ_HOLD = 8'h03;
    localparam logic [7:0] FC_WRITE_COIL = 8'h05;
    localparam logic [7:0] FC_WRITE_REG = 8'h06;
    localparam logic [7:0] FC_DIAG = 8'h08;
    localparam logic [7:0] FC_EVENT_CNT = 8'h0b;
    localparam logic [7:0] FC_WRITE_COILS = 8'h0f;
    localparam logic [7:0] FC_WRITE_REGS = 8'h10;
    localparam logic [7:0] FC_SLAVE_ID = 8'h11;
    localparam logic [7:0] FC_EXC_FLAG = 8'h80;

    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;
    localparam logic [7:0] EXC_FAIL = 8'h04;

    localparam logic [15:0] SUB_RESTART = 16'h0001;
    localparam logic [15:0] SUB_DIAG_REG = 16'h0002;
    localparam logic [15:0] SUB_CLEAR = 16'h000a;
    localparam logic [15:0] SUB_BUS_MSG = 16'h000b;
    localparam logic [15:0] SUB_COMM_ERR = 16'h000c;
    localparam logic [15:0] SUB_EXC_CNT = 16'h000d;
    localparam logic [15:0] SUB_SLAVE_MSG = 16'h000e;

    localparam logic [15:0] REG_FAULT = 16'h0007;
    localparam logic [15:0] REG_INDEX = 16'h0009;
    localparam logic [15:0] REG_CMD = 16'hc350;
    localparam logic [15:0] REG_REF = 16'hc35a;
    localparam logic [15:0] REG_STATE = 16'hc418;
    localparam logic [15:0] REG_MAV = 16'hc422;
    localparam logic [15:0] PARAM_STEP = 16'h000a;
    localparam logic [15:0] PARAM_REG_LAST = 16'hc346;
    localparam logic [15:0] TEXT_MAX_WORDS = 16'h000a;
    localparam logic [7:0] TEXT_SPACE = 8'h20;

    localparam logic [15:0] COIL_STORE = 16'h0040;
    localparam logic [16:0] COIL_COUNT = 17'h00041;
    localparam logic [15:0] COIL_MAX_READ = 16'h0010;
    localparam logic [15:0] COIL_ON = 16'hff00;
    localparam logic [15:0] COIL_OFF = 16'h0000;

    localparam int CMD_VALID_BIT = 10;
    localparam int CMD_RESET_BIT = 7;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [15:0] SLAVE_ID_WORD = 16'h005a; // arbitrary value

    typedef struct packed {
        logic valid;
        logic bad;
        logic for_me;
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] qty;
        logic [7:0] bcnt;
        logic [9:0][15:0] wdata;
    } mbs_req_s;

    typedef struct packed {
        logic valid;
        logic first;
        logic last;
        logic [7:0] func;
        logic [15:0] data;
    } mbs_rsp_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic nv;
        logic [15:0] num;
        logic [15:0] index;
        logic [3:0] word;
        logic [15:0] wdata;
    } mbs_preq_s;

    typedef enum logic [0:0] {ST_IDLE, ST_PARAM} mbs_state_e;
endpackage

// file: mbs_slave.sv
// command layer of a modbus rtu drive slave: decode, register map, replies
// assumes an upstream framer hands over one checked frame at a time and
// waits for the last reply beat before handing over the next
`timescale 1ns/1ps
`default_nettype none

module mbs_slave (
    input wire logic CLK,
    input wire logic RST_N,
    input wire mbs_pkg::mbs_req_s REQ,
    input wire logic [15:0] FAULT_CODE,
    input wire logic [15:0] STATE_WORD,
    input wire logic [15:0] MAIN_ACTUAL,
    input wire logic STORE_READY,
    input wire logic PARAM_ACK,
    input wire logic PARAM_ERR,
    input wire logic [15:0] PARAM_RDATA,
    input wire logic [4:0] PARAM_TEXT_LEN,
    output mbs_pkg::mbs_rsp_s RSP,
    output mbs_pkg::mbs_preq_s PARAM_REQ,
    output logic [15:0] CMD_APPLIED,
    output logic [15:0] SPEED_REF,
    output logic STORE_NV,
    output logic TRIP_RESET,
    output logic COMM_RESTART
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic is_param(input logic [15:0] a);
        return (a != 16'h0000) && (a % mbs_pkg::PARAM_STEP == 16'h0000)
            && (a <= mbs_pkg::PARAM_REG_LAST);
    endfunction

    function automatic logic is_rw(input logic [15:0] a);
        return a == mbs_pkg::REG_INDEX || a == mbs_pkg::REG_CMD || a == mbs_pkg::REG_REF;
    endfunction

    function automatic logic is_ro(input logic [15:0] a);
        return a == mbs_pkg::REG_FAULT || a == mbs_pkg::REG_STATE || a == mbs_pkg::REG_MAV;
    endfunction

    // blanks every character past the stored text length; a zero length leaves the word as read
    function automatic logic [15:0] pad_word(input logic [15:0] d, input logic [4:0] len,
                                             input logic [3:0] k);
        logic [5:0] c0;
        c0 = {1'b0, k, 1'b0};
        if (len == 5'h00) begin
            return d;
        end
        return {(c0 < {1'b0, len}) ? d[15:8] : mbs_pkg::TEXT_SPACE,
                (c0 + 6'h01 < {1'b0, len}) ? d[7:0] : mbs_pkg::TEXT_SPACE};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    mbs_pkg::mbs_state_e state, next_state;
    mbs_pkg::mbs_req_s hold, next_hold;
    mbs_pkg::mbs_rsp_s next_rsp;
    mbs_pkg::mbs_preq_s next_preq;
    logic [3:0] k, next_k;
    logic [15:0] cmd_word, next_cmd_word, next_applied, next_speed_ref, index, next_index;
    logic next_nv, next_trip, next_restart, clear_diag;
    logic [15:0] cnt_bus, cnt_err, cnt_exc, cnt_slave, diag_reg;
    logic [15:0] next_cnt_bus, next_cnt_err, next_cnt_exc, next_cnt_slave, next_diag_reg;
    logic [7:0] exc, fc;
    logic done;
    logic [15:0] rdata, wval;
    logic [64:0] coils;
    logic last_beat;

    assign coils = {STORE_NV, MAIN_ACTUAL, STATE_WORD, SPEED_REF, cmd_word};

    always_comb begin
        next_state = state;
        next_hold = hold;
        next_k = k;
        next_preq = PARAM_REQ;
        next_rsp = '0;
        next_cmd_word = cmd_word;
        next_applied = CMD_APPLIED;
        next_speed_ref = SPEED_REF;
        next_index = index;
        next_nv = STORE_NV;
        next_restart = 1'b0;
        clear_diag = 1'b0;
        exc = 8'h00;
        done = 1'b0;
        rdata = 16'h0000;
        fc = hold.func;
        wval = (REQ.func == mbs_pkg::FC_WRITE_REG) ? REQ.qty : REQ.wdata[0];
        last_beat = 1'b0;
        case (state)
            mbs_pkg::ST_IDLE: begin
                fc = REQ.func;
                if (REQ.valid && !REQ.bad && REQ.for_me) begin
                    next_hold = REQ;
                    rdata = REQ.qty;
                    case (REQ.func)
                        mbs_pkg::FC_READ_HOLD, mbs_pkg::FC_WRITE_REG,
                        mbs_pkg::FC_WRITE_REGS: begin
                            if (REQ.func != mbs_pkg::FC_WRITE_REG && (REQ.qty == 16'h0000
                                || (REQ.func == mbs_pkg::FC_WRITE_REGS
                                && REQ.bcnt != {REQ.qty[6:0], 1'b0}))) begin
                                exc = mbs_pkg::EXC_VALUE;
                            end else if (is_param(REQ.addr)) begin
                                if (REQ.func != mbs_pkg::FC_WRITE_REG
                                    && REQ.qty > mbs_pkg::TEXT_MAX_WORDS) begin
                                    exc = mbs_pkg::EXC_ADDR;
                                end else if (!STORE_READY) begin
                                    exc = mbs_pkg::EXC_FUNC;
                                end else begin
                                    // one store handshake per register word
                                    next_state = mbs_pkg::ST_PARAM;
                                    next_k = 4'h0;
                                    next_preq.valid = 1'b1;
                                    next_preq.write = REQ.func != mbs_pkg::FC_READ_HOLD;
                                    next_preq.nv = STORE_NV;
                                    next_preq.num = REQ.addr / mbs_pkg::PARAM_STEP;
                                    next_preq.index = index;
                                    next_preq.word = 4'h0;
                                    next_preq.wdata = wval;
                                end
                            end else if (REQ.func != mbs_pkg::FC_WRITE_REG
                                && REQ.qty != 16'h0001) begin
                                exc = mbs_pkg::EXC_ADDR;
                            end else if (REQ.func == mbs_pkg::FC_READ_HOLD) begin
                                done = 1'b1;
                                case (REQ.addr)
                                    mbs_pkg::REG_FAULT: rdata = FAULT_CODE;
                                    mbs_pkg::REG_INDEX: rdata = index;
                                    mbs_pkg::REG_CMD: rdata = cmd_word;
                                    mbs_pkg::REG_REF: rdata = SPEED_REF;
                                    mbs_pkg::REG_STATE: rdata = STATE_WORD;
                                    mbs_pkg::REG_MAV: rdata = MAIN_ACTUAL;
                                    default: begin
                                        done = 1'b0;
                                        exc = mbs_pkg::EXC_ADDR;
                                    end
                                endcase
                            end else if (is_rw(REQ.addr)) begin
                                done = 1'b1;
                                case (REQ.addr)
                                    mbs_pkg::REG_INDEX: next_index = wval;
                                    mbs_pkg::REG_REF: next_speed_ref = wval;
                                    default: begin
                                        next_cmd_word = wval;
                                        if (wval[mbs_pkg::CMD_VALID_BIT]) begin
                                            next_applied = wval;
                                        end
                                    end
                                endcase
                            end else begin
                                exc = mbs_pkg::EXC_ADDR;
                            end
                        end
                        mbs_pkg::FC_READ_COILS: begin
                            if (REQ.qty == 16'h0000 || REQ.qty > mbs_pkg::COIL_MAX_READ) begin
                                exc = mbs_pkg::EXC_VALUE;
                            end else if ({1'b0, REQ.addr} + {1'b0, REQ.qty}
                                > mbs_pkg::COIL_COUNT) begin
                                exc = mbs_pkg::EXC_ADDR;
                            end else begin
                                done = 1'b1;
                                rdata = 16'(coils >> REQ.addr)
                                    & 16'((17'h00001 << REQ.qty[4:0]) - 17'h00001);
                            end
                        end
                        mbs_pkg::FC_WRITE_COIL, mbs_pkg::FC_WRITE_COILS: begin
                            if (REQ.func == mbs_pkg::FC_WRITE_COIL ? (REQ.qty != mbs_pkg::COIL_ON
                                && REQ.qty != mbs_pkg::COIL_OFF)
                                : (REQ.qty != 16'h0001 || REQ.bcnt != 8'h01)) begin
                                exc = mbs_pkg::EXC_VALUE;
                            end else if (REQ.addr != mbs_pkg::COIL_STORE) begin
                                exc = mbs_pkg::EXC_ADDR;
                            end else begin
                                done = 1'b1;
                                next_nv = (REQ.func == mbs_pkg::FC_WRITE_COIL)
                                    ? REQ.qty[15] : REQ.wdata[0][0];
                            end
                        end
                        mbs_pkg::FC_EVENT_CNT: begin
                            done = 1'b1;
                            rdata = cnt_bus;
                        end
                        mbs_pkg::FC_SLAVE_ID: begin
                            done = 1'b1;
                            rdata = mbs_pkg::SLAVE_ID_WORD;
                        end
                        mbs_pkg::FC_DIAG: begin
                            done = 1'b1;
                            case (REQ.addr)
                                mbs_pkg::SUB_RESTART: begin
                                    next_restart = 1'b1;
                                    clear_diag = 1'b1;
                                end
                                mbs_pkg::SUB_DIAG_REG: rdata = diag_reg;
                                mbs_pkg::SUB_CLEAR: clear_diag = 1'b1;
                                mbs_pkg::SUB_BUS_MSG: rdata = cnt_bus;
                                mbs_pkg::SUB_COMM_ERR: rdata = cnt_err;
                                mbs_pkg::SUB_EXC_CNT: rdata = cnt_exc;
                                mbs_pkg::SUB_SLAVE_MSG: rdata = cnt_slave;
                                default: begin
                                    done = 1'b0;
                                    exc = mbs_pkg::EXC_VALUE;
                                end
                            endcase
                        end
                        default: exc = mbs_pkg::EXC_FUNC;
                    endcase
                end
            end
            mbs_pkg::ST_PARAM: begin
                if (PARAM_ACK) begin
                    last_beat = (hold.func == mbs_pkg::FC_WRITE_REG)
                        || ({12'h000, k} == hold.qty - 16'h0001);
                    if (PARAM_ERR) begin
                        exc = mbs_pkg::EXC_FAIL;
                    end else if (!PARAM_REQ.write) begin
                        next_rsp.valid = 1'b1;
                        next_rsp.first = k == 4'h0;
                        next_rsp.last = last_beat;
                        next_rsp.func = hold.func;
                        next_rsp.data = pad_word(PARAM_RDATA, PARAM_TEXT_LEN, k);
                    end else if (last_beat) begin
                        done = 1'b1;
                        rdata = hold.qty;
                    end
                    if (PARAM_ERR || last_beat) begin
                        next_state = mbs_pkg::ST_IDLE;
                        next_preq.valid = 1'b0;
                    end else begin
                        next_k = k + 4'h1;
                        next_preq.word = k + 4'h1;
                        next_preq.wdata = hold.wdata[k + 4'h1];
                    end
                end
            end
            default: next_state = mbs_pkg::ST_IDLE;
        endcase
        if (exc != 8'h00) begin
            next_rsp = '{1'b1, 1'b1, 1'b1, fc | mbs_pkg::FC_EXC_FLAG, {8'h00, exc}};
        end else if (done) begin
            next_rsp = '{1'b1, 1'b1, 1'b1, fc, rdata};
        end
        next_trip = next_applied[mbs_pkg::CMD_RESET_BIT]
            && !CMD_APPLIED[mbs_pkg::CMD_RESET_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // a clear in the same cycle as a counted event keeps that event
    always_comb begin
        next_cnt_bus = (clear_diag ? 16'h0000 : cnt_bus)
            + {15'h0000, REQ.valid && !REQ.bad};
        next_cnt_err = (clear_diag ? 16'h0000 : cnt_err) + {15'h0000, REQ.valid && REQ.bad};
        next_cnt_slave = (clear_diag ? 16'h0000 : cnt_slave)
            + {15'h0000, REQ.valid && !REQ.bad && REQ.for_me};
        next_cnt_exc = (clear_diag ? 16'h0000 : cnt_exc) + {15'h0000, exc != 8'h00};
        next_diag_reg = (exc != 8'h00) ? {8'h00, exc} : (clear_diag ? 16'h0000 : diag_reg);
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state <= mbs_pkg::ST_IDLE;
            hold <= '0;
            k <= 4'h0;
            RSP <= '0;
            PARAM_REQ <= '0;
            cmd_word <= mbs_pkg::RESET_WORD;
            CMD_APPLIED <= mbs_pkg::RESET_WORD;
            SPEED_REF <= mbs_pkg::RESET_WORD;
            index <= mbs_pkg::RESET_WORD;
            STORE_NV <= 1'b0;
            TRIP_RESET <= 1'b0;
            COMM_RESTART <= 1'b0;
            cnt_bus <= 16'h0000;
            cnt_err <= 16'h0000;
            cnt_exc <= 16'h0000;
            cnt_slave <= 16'h0000;
            diag_reg <= 16'h0000;
        end else begin
            state <= next_state;
            hold <= next_hold;
            k <= next_k;
            RSP <= next_rsp;
            PARAM_REQ <= next_preq;
            cmd_word <= next_cmd_word;
            CMD_APPLIED <= next_applied;
            SPEED_REF <= next_speed_ref;
            index <= next_index;
            STORE_NV <= next_nv;
            TRIP_RESET <= next_trip;
            COMM_RESTART <= next_restart;
            cnt_bus <= next_cnt_bus;
            cnt_err <= next_cnt_err;
            cnt_exc <= next_cnt_exc;
            cnt_slave <= next_cnt_slave;
            diag_reg <= next_diag_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_exc_reply_form: assert property (RSP.valid && RSP.func[7] |-> RSP.first && RSP.last
        && RSP.data >= 16'h0001 && RSP.data <= 16'h0004)
        else $error("malformed exception reply");
    a_unknown_func: assert property (state == mbs_pkg::ST_IDLE && REQ.valid && !REQ.bad
        && REQ.for_me && REQ.func == 8'h07 |=> RSP.valid && RSP.func == 8'h87
        && RSP.data == 16'h0001)
        else $error("unknown function not refused with code 1");
    a_coil_range: assert property (state == mbs_pkg::ST_IDLE && REQ.valid && !REQ.bad
        && REQ.for_me && REQ.func == mbs_pkg::FC_READ_COILS && REQ.qty == 16'h0002
        |=> RSP.valid && (RSP.func[7] == ($past(REQ.addr) >= 16'h0040)))
        else $error("coil range edge handled wrongly");
    a_write_len: assert property (state == mbs_pkg::ST_IDLE && REQ.valid && !REQ.bad
        && REQ.for_me && REQ.func == mbs_pkg::FC_WRITE_REGS && REQ.qty == 16'h0002
        && REQ.bcnt != 8'h04 |=> RSP.valid && RSP.data == 16'h0003)
        else $error("byte count mismatch not refused");
    a_param_fail: assert property (state == mbs_pkg::ST_PARAM && PARAM_ACK && PARAM_ERR
        |=> RSP.valid && RSP.func[7] && RSP.data == 16'h0004 && !PARAM_REQ.valid)
        else $error("store failure not reported");
    a_param_target: assert property (PARAM_REQ.valid |-> PARAM_REQ.num * 16'h000a
        == hold.addr && PARAM_REQ.index == index && PARAM_REQ.nv == STORE_NV)
        else $error("parameter request fields wrong");
    a_cmd_gate: assert property ($changed(CMD_APPLIED) |-> CMD_APPLIED[10]
        && CMD_APPLIED == cmd_word)
        else $error("command word applied without valid bit");
    a_trip_edge: assert property (TRIP_RESET |-> CMD_APPLIED[7]
        && !$past(CMD_APPLIED[7]) ##1 !TRIP_RESET)
        else $error("trip reset not a single rising edge pulse");
    a_bad_count: assert property (REQ.valid && REQ.bad && !clear_diag
        |=> cnt_err == $past(cnt_err) + 16'h0001 && $stable(cnt_bus))
        else $error("bad frame not counted");
endmodule

`default_nettype wire

// file: mbs_store_model.sv
// parameter store stand-in: acks each word that the slave asks for
// assumes the slave holds a store request until it sees the ack
`timescale 1ns/1ps
`default_nettype none

module mbs_store_model (
    input wire logic CLK,
    input wire logic RST_N,
    input wire mbs_pkg::mbs_preq_s PREQ,
    input wire logic FAIL,
    input wire logic SLOW,
    output logic ACK,
    output logic ERR,
    output logic [15:0] RDATA
);
    logic [1:0] wait_cnt;
    logic [15:0] word_val;

    // a read word names its parameter and word, so misrouted beats show
    assign word_val = {PREQ.num[11:0], PREQ.word};
    // outside an ack the data is inverted so a stale sample cannot match
    assign RDATA = ACK ? word_val : ~word_val;
    assign ERR = ACK & FAIL;

    always_ff @(posedge CLK) begin
        if (!RST_N || !PREQ.valid || ACK) begin
            wait_cnt <= 2'h0;
            ACK <= 1'b0;
        end else if (!SLOW || wait_cnt == 2'h3) begin
            ACK <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule

`default_nettype wire

// file: tb.sv
// self-checking bench for the drive parameter slave command layer
// assumes one frame at a time, next frame only after the last reply beat
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    mbs_pkg::mbs_req_s REQ = '0;
    mbs_pkg::mbs_rsp_s RSP;
    mbs_pkg::mbs_preq_s PARAM_REQ;
    logic STORE_READY = 1'b1;
    logic ack, err, fail = 1'b0, slow = 1'b0;
    logic [15:0] rdata, cmd_applied, speed_ref;
    logic [4:0] text_len = 5'h00;
    logic store_nv, trip_reset, restart;
    logic [23:0] got [12];
    logic [63:0] rows [25];
    int nb, trips = 0, restarts = 0, bad_count = 0, comparisons = 0;

    always #2 CLK = ~CLK;
    // pulses are counted mid-cycle, where the registered outputs have settled
    always @(negedge CLK) begin
        if (trip_reset === 1'b1) trips++;
        if (restart === 1'b1) restarts++;
    end

    mbs_slave uut (.CLK(CLK), .RST_N(RST_N), .REQ(REQ), .FAULT_CODE(16'h0123),
        .STATE_WORD(16'h4567), .MAIN_ACTUAL(16'h89ab), .STORE_READY(STORE_READY),
        .PARAM_ACK(ack), .PARAM_ERR(err), .PARAM_RDATA(rdata), .PARAM_TEXT_LEN(text_len),
        .RSP(RSP), .PARAM_REQ(PARAM_REQ), .CMD_APPLIED(cmd_applied), .SPEED_REF(speed_ref),
        .STORE_NV(store_nv), .TRIP_RESET(trip_reset), .COMM_RESTART(restart));
    mbs_store_model store (.CLK(CLK), .RST_N(RST_N), .PREQ(PARAM_REQ), .FAIL(fail),
        .SLOW(slow), .ACK(ack), .ERR(err), .RDATA(rdata));

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask

    // drives one frame and gathers reply beats until the last one
    task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q,
        input logic bd = 1'b0, input logic [7:0] bc = 8'h00);
        int t;
        nb = 0;
        @(posedge CLK);
        REQ <= '{valid: 1'b1, bad: bd, for_me: 1'b1, func: f, addr: a, qty: q,
            bcnt: (bc == 8'h00) ? 8'(2 * q) : bc, wdata: {144'h0, q}};
        @(posedge CLK);
        REQ.valid <= 1'b0;
        // a bad frame is only watched a few cycles for a reply that must not come
        for (t = 0; t < (bd ? 3 : 60); t++) begin
            #1;
            if (RSP.valid === 1'b1 && nb < 12) begin
                got[nb] = {RSP.func, RSP.data};
                nb++;
                if (RSP.last === 1'b1) break;
            end
            @(posedge CLK);
        end
        if (t == 60) begin
            bad_count++;
            $display("unexpected at %0t: no reply", $time);
            test_done();
        end else begin
            $display("frame %h %h done", f, a);
        end
    endtask

    initial begin
        repeat (20000) @(posedge CLK);
        bad_count++;
        $display("unexpected at %0t: run too long", $time);
        test_done();
    end

    initial begin
        // func, addr, qty or value, reply func, reply data
        rows = '{64'h06c350040006_0400, 64'h06000900030600_03, 64'h03000700010301_23,
            64'h03c41800010345_67, 64'h03c4220001038_9ab, 64'h03000700028300_02,
            64'h06c41800018600_02, 64'h07000000008700_01, 64'h08000f00008800_03,
            64'h08000200000800_03, 64'h050040ff0005ff_00, 64'h11000000001100_5a,
            64'h01000000100104_00, 64'h08000a00000800_00, 64'h08000d00000800_00,
            64'h0b000000000b00_02, 64'h08000e00000800_03, 64'h08000b00000800_04,
            64'h06c35a123406_1234, 64'h03c35a000103_1234, 64'h03000900010300_03,
            64'h10000a00009000_03, 64'h01003f00020100_03, 64'h01004000028100_02,
            64'h0f004000018f00_03};
        repeat (16) @(posedge CLK);
        RST_N <= 1'b1;
        #1;
        chk({RSP.valid, PARAM_REQ.valid, trip_reset, restart, 3'h0, store_nv,
            cmd_applied}, 24'h0);
        chk({8'h0, speed_ref}, 24'h0);
        for (int i = 0; i < 25; i++) begin
            xfer(rows[i][63:56], rows[i][55:40], rows[i][39:24]);
            chk({8'(nb), got[0]}, {8'h01, rows[i][23:0]});
        end
        chk({7'h0, store_nv, cmd_applied}, 24'h010400);
        chk({8'h0, speed_ref}, 24'h001234);
        xfer(8'h06, 16'hc350, 16'h0080);
        chk({8'h0, cmd_applied}, 24'h000400);
        xfer(8'h06, 16'hc350, 16'h0480);
        xfer(8'h06, 16'hc350, 16'h0480);
        chk(24'(trips), 24'h1);
        xfer(8'h10, 16'h000a, 16'h0002, 1'b0, 8'h03);
        chk(got[0], 24'h900003);
        xfer(8'h08, 16'h0001, 16'h0000);
        chk(got[0], 24'h080000);
        xfer(8'h03, 16'h0000, 16'h0001, 1'b1);
        chk({8'(nb), 8'(restarts), 8'h00}, 24'h000100);
        xfer(8'h08, 16'h000c, 16'h0000);
        chk(got[0], 24'h080001);
        slow <= 1'b1;
        xfer(8'h03, 16'h000a, 16'h0002);
        chk({8'(nb), got[0][15:0]}, 24'h020010);
        chk(got[1], 24'h030011);
        slow <= 1'b0;
        xfer(8'h03, 16'hc346, 16'h0001);
        chk(got[0], 24'h033870);
        text_len <= 5'h03;
        xfer(8'h03, 16'h0014, 16'h0003);
        chk({got[0][15:0], 8'(nb)}, 24'h002003);
        chk({got[1][15:0], got[2][15:8]}, 24'h002020);
        text_len <= 5'h00;
        xfer(8'h10, 16'h000a, 16'h0002);
        chk(got[0], 24'h100002);
        fail <= 1'b1;
        xfer(8'h03, 16'h000a, 16'h0001);
        chk(got[nb - 1], 24'h830004);
        fail <= 1'b0;
        @(posedge CLK);
        RST_N <= 1'b0;
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        #1;
        chk({RSP.valid, PARAM_REQ.valid, trip_reset, restart, 3'h0, store_nv,
            cmd_applied}, 24'h0);
        chk({8'h0, speed_ref}, 24'h0);
        STORE_READY <= 1'b0;
        xfer(8'h03, 16'h000a, 16'h0001);
        chk(got[0], 24'h830001);
        test_done();
    end
endmodule

`default_nettype wire
